/* pkg/dac_defs.svh */
`ifndef DAC_DEFS_SVH
`define DAC_DEFS_SVH

// ----------------------------------------
// Bus addressing and command byte layout
// ----------------------------------------
`define DAC_DEV_ADDR     7'h60
`define DAC_CMD_READ     2'h3
`define DAC_CMD_ADR_HI   7
`define DAC_CMD_ADR_LO   3
`define DAC_CMD_OP_HI    2
`define DAC_CMD_OP_LO    1
`define DAC_CTRL_RW      0

// ----------------------------------------
// Memory map and word indices
// ----------------------------------------
`define DAC_ADR_VOL0     5'h00
`define DAC_ADR_VOL1     5'h01
`define DAC_ADR_VREF     5'h08
`define DAC_ADR_PD       5'h09
`define DAC_ADR_GAIN     5'h0A
`define DAC_IDX_VOL0     3'h0
`define DAC_IDX_VOL1     3'h1
`define DAC_IDX_VREF     3'h2
`define DAC_IDX_PD       3'h3
`define DAC_IDX_GAIN     3'h4
`define DAC_IDX_NONE     3'h7
`define DAC_NWORDS       5
`define DAC_PTR_RST      5'h00

// ----------------------------------------
// Timing and buffer layout
// ----------------------------------------
`define DAC_CORE_NS      5
`define DAC_QUARTER_NS   30
`define DAC_QUARTER_CYC  ((`DAC_QUARTER_NS + `DAC_CORE_NS - 1) / `DAC_CORE_NS)
// Top bit of the link reset counter stays set for 64 core cycles after release
`define DAC_LRST_LOAD    8'hBF
// Bus clock falls the host makes after reset before it takes commands
`define DAC_WAKE_FALLS   4'hC
`define DAC_BUF_HEAD     1'h0
`define DAC_BUF_TAIL     1'h1

`endif

/* pkg/dac_pkg.sv */
package dac_pkg;

  typedef logic [15:0] dac_word_t;
  typedef logic [4:0]  dac_addr_t;

  typedef enum logic [2:0] {
    DS_IDLE   = 3'h0,
    DS_CTRL   = 3'h1,
    DS_CMD    = 3'h2,
    DS_TX     = 3'h3,
    DS_IGNORE = 3'h4
  } dac_dev_state_t;

  typedef enum logic [2:0] {
    HS_IDLE   = 3'h0,
    HS_START1 = 3'h1,
    HS_CTRLW  = 3'h2,
    HS_CMD    = 3'h3,
    HS_START2 = 3'h4,
    HS_CTRLR  = 3'h5,
    HS_READ   = 3'h6,
    HS_STOP   = 3'h7
  } dac_host_state_t;

endpackage

/* pkg/dac_i2c_if.sv */
`timescale 1ns/1ps
interface dac_i2c_if;
  logic scl;
  logic host_sda_out;
  logic host_sda_oe_n;
  logic dev_sda_out;
  logic dev_sda_oe_n;
  logic sda;

  // Open drain with pull-up: any enabled low driver wins
  assign sda = ~((~host_sda_oe_n & ~host_sda_out) | (~dev_sda_oe_n & ~dev_sda_out));

  modport host (output scl, host_sda_out, host_sda_oe_n, input sda);
  modport dev  (input scl, sda, output dev_sda_out, dev_sda_oe_n);
endinterface

/* core/dac_dev.sv */
`timescale 1ns/1ps
`include "dac_defs.svh"
module dac_dev
  import dac_pkg::*;
(
  // Core clock and reset
  input  wire logic      core_clk,
  input  wire logic      rst,
  // Pins
  input  wire logic      output_latch_pin,
  input  wire logic      high_voltage_command_flag,
  // Register contents from the DAC core
  input  wire dac_word_t vol_reg0,
  input  wire dac_word_t vol_reg1,
  input  wire dac_word_t vol_out0,
  input  wire dac_word_t vol_out1,
  input  wire dac_word_t vref_cfg,
  input  wire dac_word_t pd_cfg,
  input  wire dac_word_t gain_cfg,
  // Status
  output logic           cmd_error,
  // Bus
  dac_i2c_if.dev         lnk
);

  function automatic logic [2:0] addr_to_idx(input dac_addr_t a);
    case (a)
      `DAC_ADR_VOL0: addr_to_idx = `DAC_IDX_VOL0;
      `DAC_ADR_VOL1: addr_to_idx = `DAC_IDX_VOL1;
      `DAC_ADR_VREF: addr_to_idx = `DAC_IDX_VREF;
      `DAC_ADR_PD:   addr_to_idx = `DAC_IDX_PD;
      `DAC_ADR_GAIN: addr_to_idx = `DAC_IDX_GAIN;
      default:       addr_to_idx = `DAC_IDX_NONE;
    endcase
  endfunction

  // ----------------------------------------
  // Core side: snapshot handed to the link
  // ----------------------------------------
  // The hold words only change while the handshake is idle, so the link
  // side may copy them as a whole once it sees the request toggle.
  dac_word_t hold      [`DAC_NWORDS];
  dac_word_t next_hold [`DAC_NWORDS];
  logic      req;
  logic      next_req;
  logic      latch_s1;
  logic      latch_s;
  logic      ack_s1;
  logic      ack_s2;
  logic      err_s1;
  logic      seen;
  logic      err_l;
  logic [7:0] rst_cnt;
  logic [7:0] next_rst_cnt;

  always_comb begin
    next_req  = req;
    next_hold = hold;
    // Link reset outlives core reset: the bus clock only runs after release
    next_rst_cnt = rst ? `DAC_LRST_LOAD : rst_cnt - {7'h00, rst_cnt[7]};
    if (ack_s2 == req) begin
      next_hold[`DAC_IDX_VOL0] = latch_s ? vol_out0 : vol_reg0;
      next_hold[`DAC_IDX_VOL1] = latch_s ? vol_out1 : vol_reg1;
      next_hold[`DAC_IDX_VREF] = vref_cfg;
      next_hold[`DAC_IDX_PD]   = pd_cfg;
      next_hold[`DAC_IDX_GAIN] = gain_cfg;
      next_req                 = ~req;
    end
  end

  always_ff @(posedge core_clk) begin
    latch_s1  <= output_latch_pin;
    latch_s   <= latch_s1;
    ack_s1    <= seen;
    ack_s2    <= ack_s1;
    err_s1    <= err_l;
    cmd_error <= err_s1;
    rst_cnt   <= next_rst_cnt;
    if (rst) begin
      req  <= 1'b0;
      hold <= '{default: 16'h0000};
    end else begin
      req  <= next_req;
      hold <= next_hold;
    end
  end

  // ----------------------------------------
  // Link side: bit engine on the bus clock
  // ----------------------------------------
  // Bits are sampled on the rising edge; all state moves on the falling
  // edge. A data change while the clock was high shows as a difference
  // between the two samples, which is how Start and Stop are seen without
  // any edge on the data line itself.
  dac_dev_state_t st;
  dac_dev_state_t next_st;
  dac_word_t      snap      [`DAC_NWORDS];
  dac_word_t      next_snap [`DAC_NWORDS];
  dac_word_t      word;
  dac_word_t      next_word;
  dac_addr_t      ptr;
  dac_addr_t      next_ptr;
  logic [3:0]     cnt;
  logic [3:0]     next_cnt;
  logic [7:0]     rx;
  logic [7:0]     next_rx;
  logic [7:0]     tx;
  logic [7:0]     next_tx;
  logic [7:0]     byte_in;
  logic           lo;
  logic           next_lo;
  logic           next_oe_n;
  logic           next_seen;
  logic           sda_r;
  logic           lrst_s1;
  logic           lrst;
  logic           req_s1;
  logic           req_s2;

  always_ff @(posedge lnk.scl) begin
    sda_r <= lnk.sda;
  end

  always_comb begin
    next_st   = st;
    next_cnt  = cnt;
    next_rx   = rx;
    next_tx   = tx;
    next_lo   = lo;
    next_word = word;
    next_ptr  = ptr;
    next_oe_n = 1'b1;
    next_seen = seen;
    next_snap = snap;
    byte_in   = {rx[6:0], sda_r};
    if (req_s2 != seen) begin
      next_snap = hold;
      next_seen = req_s2;
    end
    if (lrst) begin
      next_seen = 1'b0;
      next_st  = DS_IDLE;
      next_cnt = 4'h0;
      next_lo  = 1'b0;
      next_ptr = `DAC_PTR_RST;
    end else if (sda_r && !lnk.sda) begin
      next_st  = DS_CTRL;
      next_cnt = 4'h0;
    end else if (!sda_r && lnk.sda) begin
      next_st = DS_IDLE;
    end else begin
      case (st)
        DS_CTRL, DS_CMD: begin
          if (cnt != 4'h8) begin
            next_rx  = byte_in;
            next_cnt = cnt + 4'h1;
            if (cnt == 4'h7) begin
              if (st == DS_CTRL) begin
                if (byte_in[7:1] == `DAC_DEV_ADDR) begin
                  next_oe_n = 1'b0;
                end else begin
                  next_st = DS_IDLE;
                end
              end else if (byte_in[`DAC_CMD_OP_HI:`DAC_CMD_OP_LO] == `DAC_CMD_READ &&
                           addr_to_idx(byte_in[`DAC_CMD_ADR_HI:`DAC_CMD_ADR_LO]) != `DAC_IDX_NONE) begin
                next_oe_n = 1'b0;
                next_ptr  = byte_in[`DAC_CMD_ADR_HI:`DAC_CMD_ADR_LO];
              end else begin
                next_st = DS_IGNORE;
              end
            end
          end else begin
            next_cnt = 4'h0;
            if (st == DS_CMD) begin
              // Read command may be repeated in the same frame
              next_word = snap[addr_to_idx(ptr)];
            end else if (rx[`DAC_CTRL_RW]) begin
              next_st   = DS_TX;
              next_lo   = 1'b0;
              next_word = snap[addr_to_idx(ptr)];
              next_tx   = next_word[15:8];
              next_oe_n = next_tx[7];
            end else begin
              next_st = DS_CMD;
            end
          end
        end
        DS_TX: begin
          if (cnt < 4'h7) begin
            next_tx   = {tx[6:0], 1'b0};
            next_oe_n = next_tx[7];
            next_cnt  = cnt + 4'h1;
          end else if (cnt == 4'h7) begin
            next_cnt = 4'h8;
          end else if (!sda_r) begin
            next_cnt = 4'h0;
            if (!lo) begin
              next_tx = word[7:0];
              next_lo = 1'b1;
            end else begin
              next_word = snap[addr_to_idx(ptr)];
              next_tx   = next_word[15:8];
              next_lo   = 1'b0;
            end
            next_oe_n = next_tx[7];
          end else begin
            next_st = DS_IDLE;
          end
        end
        default: begin
          // Idle or rejected: data stays released, nothing is acknowledged
          next_st = st;
        end
      endcase
    end
  end

  // High voltage flag does not enter the read path at all

  always_ff @(negedge lnk.scl) begin
    lrst_s1          <= rst_cnt[7];
    lrst             <= lrst_s1;
    req_s1           <= req;
    req_s2           <= req_s1;
    st               <= next_st;
    cnt              <= next_cnt;
    rx               <= next_rx;
    tx               <= next_tx;
    lo               <= next_lo;
    word             <= next_word;
    ptr              <= next_ptr;
    seen             <= next_seen;
    snap             <= next_snap;
    err_l            <= (next_st == DS_IGNORE);
    lnk.dev_sda_oe_n <= lrst ? 1'b1 : next_oe_n;
  end

  // Open drain: the data value is tied low from time zero, only the enable moves
  assign lnk.dev_sda_out = 1'b0;

endmodule

/* core/dac_host.sv */
`timescale 1ns/1ps
`include "dac_defs.svh"
module dac_host
  import dac_pkg::*;
(
  // Clock and reset
  input  wire logic      core_clk,
  input  wire logic      rst,
  // Command request
  input  wire logic      cmd_valid,
  output logic           cmd_ready,
  input  wire logic      cmd_last,
  input  wire dac_addr_t cmd_addr,
  input  wire logic [3:0] cmd_words,
  // Read data stream
  output dac_word_t      rd_data,
  output logic           rd_valid,
  input  wire logic      rd_ready,
  // Status
  output logic           done,
  output logic           nack,
  // Bus
  dac_i2c_if.host        lnk
);

  // ----------------------------------------
  // Bit engine
  // ----------------------------------------
  // Every bus operation is four quarters: clock low, data set, clock high,
  // sample or data edge. Start and Stop use the same frame so the target
  // always sees a low clock before the data edge.
  dac_host_state_t st;
  dac_host_state_t next_st;
  dac_addr_t       addr;
  dac_addr_t       next_addr;
  dac_word_t       push_data;
  logic [3:0]      div;
  logic [3:0]      next_div;
  logic [3:0]      bitc;
  logic [3:0]      next_bitc;
  logic [3:0]      left;
  logic [3:0]      next_left;
  logic [3:0]      wake;
  logic [3:0]      next_wake;
  logic [7:0]      sh;
  logic [7:0]      next_sh;
  logic [7:0]      hi;
  logic [7:0]      next_hi;
  logic [1:0]      q;
  logic [1:0]      next_q;
  logic [1:0]      fcnt;
  logic            tick;
  logic            stall;
  logic            out_bit;
  logic            is_start;
  logic            is_stop;
  logic            push;
  logic            last;
  logic            next_last;
  logic            lo;
  logic            next_lo;
  logic            scl;
  logic            next_scl;
  logic            oe_n;
  logic            next_oe_n;
  logic            next_cmd_ready;
  logic            next_done;
  logic            next_nack;
  logic            sda_s1;
  logic            sda_s;

  always_comb begin
    tick      = (div == 4'(`DAC_QUARTER_CYC - 1));
    is_start  = (st == HS_START1) || (st == HS_START2);
    is_stop   = (st == HS_STOP);
    out_bit   = (st == HS_READ) ? ((bitc != 4'h8) || (lo && left == 4'h1)) : ((bitc == 4'h8) || sh[7]);
    // Holding the clock low before the ack keeps a full buffer from overflowing
    stall     = (st == HS_READ) && lo && (bitc == 4'h8) && (q == 2'h1) && (fcnt == 2'h2);
    push      = 1'b0;
    push_data = {hi, sh};
    next_div  = tick ? 4'h0 : div + 4'h1;
    next_st   = st;
    next_addr = addr;
    next_bitc = bitc;
    next_left = left;
    next_wake = wake;
    next_sh   = sh;
    next_hi   = hi;
    next_q    = q;
    next_last = last;
    next_lo   = lo;
    next_scl  = scl;
    next_oe_n = oe_n;
    next_cmd_ready = cmd_ready;
    next_done = 1'b0;
    next_nack = nack;
    if (rst) begin
      // Divider and clock start from known values; the clock runs after release
      next_div  = 4'h0;
      next_scl  = 1'b1;
      next_wake = `DAC_WAKE_FALLS;
      next_st   = HS_IDLE;
      next_q    = 2'h0;
      next_oe_n = 1'b1;
      next_cmd_ready = 1'b0;
      next_nack = 1'b0;
      next_lo   = 1'b0;
      next_bitc = 4'h0;
    end else if (wake != 4'h0) begin
      // Free-running clock with data released lets the target clear its link logic
      next_oe_n = 1'b1;
      if (tick) begin
        next_scl  = ~scl;
        next_wake = scl ? wake - 4'h1 : wake;
      end
    end else if (st == HS_IDLE) begin
      next_scl  = 1'b1;
      next_oe_n = 1'b1;
      next_q    = 2'h0;
      next_cmd_ready = 1'b1;
      if (cmd_valid && cmd_ready) begin
        next_cmd_ready = 1'b0;
        next_nack = 1'b0;
        next_st   = HS_START1;
        next_last = cmd_last;
        next_addr = cmd_addr;
        next_left = (cmd_words == 4'h0) ? 4'h1 : cmd_words;
        next_div  = 4'h0;
      end
    end else if (tick && !stall) begin
      next_q = q + 2'h1;
      case (q)
        2'h0: next_scl = 1'b0;
        2'h1: next_oe_n = is_start ? 1'b1 : (is_stop ? 1'b0 : out_bit);
        2'h2: next_scl = 1'b1;
        default: begin
          if (is_start) next_oe_n = 1'b0;
          else if (is_stop) next_oe_n = 1'b1;
          case (st)
            HS_START1: begin
              next_st   = last ? HS_CTRLR : HS_CTRLW;
              next_sh   = {`DAC_DEV_ADDR, last};
              next_bitc = 4'h0;
            end
            HS_START2: begin
              next_st   = HS_CTRLR;
              next_sh   = {`DAC_DEV_ADDR, 1'b1};
              next_bitc = 4'h0;
            end
            HS_STOP: begin
              next_st   = HS_IDLE;
              next_done = 1'b1;
            end
            default: begin
              if (bitc != 4'h8) begin
                next_sh   = {sh[6:0], sda_s};
                next_bitc = bitc + 4'h1;
              end else begin
                next_bitc = 4'h0;
                if (st != HS_READ && sda_s) begin
                  next_nack = 1'b1;
                  next_st   = HS_STOP;
                end else begin
                  case (st)
                    HS_CTRLW: begin
                      next_st = HS_CMD;
                      next_sh = {addr, `DAC_CMD_READ, 1'b0};
                    end
                    HS_CMD: next_st = HS_START2;
                    HS_CTRLR: begin
                      next_st = HS_READ;
                      next_lo = 1'b0;
                    end
                    default: begin
                      if (!lo) begin
                        next_hi = sh;
                        next_lo = 1'b1;
                      end else begin
                        push      = 1'b1;
                        next_lo   = 1'b0;
                        next_left = left - 4'h1;
                        if (left == 4'h1) next_st = HS_STOP;
                      end
                    end
                  endcase
                end
              end
            end
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    sda_s1            <= lnk.sda;
    sda_s             <= sda_s1;
    div               <= next_div;
    st                <= next_st;
    addr              <= next_addr;
    bitc              <= next_bitc;
    left              <= next_left;
    wake              <= next_wake;
    sh                <= next_sh;
    hi                <= next_hi;
    q                 <= next_q;
    last              <= next_last;
    lo                <= next_lo;
    scl               <= next_scl;
    oe_n              <= next_oe_n;
    cmd_ready         <= next_cmd_ready;
    done              <= next_done;
    nack              <= next_nack;
    lnk.scl           <= next_scl;
    lnk.host_sda_oe_n <= next_oe_n;
    lnk.host_sda_out  <= 1'b0;
  end

  // ----------------------------------------
  // Two-entry read buffer
  // ----------------------------------------
  dac_word_t  buf_q    [2];
  dac_word_t  next_buf [2];
  logic [1:0] next_fcnt;
  logic       pop;

  always_comb begin
    pop       = rd_valid && rd_ready;
    next_buf  = buf_q;
    next_fcnt = fcnt;
    case ({push, pop})
      2'b10: begin
        next_buf[fcnt == 2'h0 ? `DAC_BUF_HEAD : `DAC_BUF_TAIL] = push_data;
        next_fcnt = fcnt + 2'h1;
      end
      2'b01: begin
        next_buf[`DAC_BUF_HEAD] = buf_q[`DAC_BUF_TAIL];
        next_fcnt = fcnt - 2'h1;
      end
      2'b11: begin
        if (fcnt == 2'h1) begin
          next_buf[`DAC_BUF_HEAD] = push_data;
        end else begin
          next_buf[`DAC_BUF_HEAD] = buf_q[`DAC_BUF_TAIL];
          next_buf[`DAC_BUF_TAIL] = push_data;
        end
      end
      default: next_fcnt = fcnt;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      fcnt     <= 2'h0;
      rd_valid <= 1'b0;
      buf_q    <= '{default: 16'h0000};
    end else begin
      fcnt     <= next_fcnt;
      rd_valid <= (next_fcnt != 2'h0);
      buf_q    <= next_buf;
    end
  end

  assign rd_data = buf_q[`DAC_BUF_HEAD];

endmodule

/* verification/dac_link_properties.sv */
`timescale 1ns/1ps
`include "dac_defs.svh"
module dac_link_properties (
  // Core domain
  input wire logic core_clk,
  input wire logic rst,
  // Bus wires
  input wire logic scl,
  input wire logic host_sda_out,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_out,
  input wire logic dev_sda_oe_n,
  input wire logic sda
);
  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic       scl_q, sda_q, rd, err, next_rd, next_err;
  logic [3:0] cnt, idx, next_cnt, next_idx;
  logic [7:0] sh, next_sh;
  wire        rise   = scl & ~scl_q;
  wire        start  = scl & scl_q & sda_q & ~sda;
  wire        stop   = scl & scl_q & ~sda_q & sda;
  wire        ninth  = rise & (cnt == 4'h8);
  wire        cmd_ok = (sh[2:1] == `DAC_CMD_READ) &&
                       (sh[7:3] inside {`DAC_ADR_VOL0, `DAC_ADR_VOL1, `DAC_ADR_VREF, `DAC_ADR_PD, `DAC_ADR_GAIN});

  always_comb begin
    next_cnt = cnt;
    next_idx = idx;
    next_sh  = sh;
    next_rd  = rd;
    next_err = err;
    if (start) begin
      next_cnt = 4'h0;
      next_idx = 4'h0;
      next_err = 1'b0;
    end else if (rise) begin
      next_cnt = (cnt == 4'h9) ? 4'h1 : cnt + 4'h1;
      // Saturate so long reads never alias the control byte slot
      if (cnt == 4'h9 && idx != 4'hF) next_idx = idx + 4'h1;
      if (cnt != 4'h8) next_sh = {sh[6:0], sda};
      if (ninth && idx == 4'h0) next_rd = sh[0];
      if (ninth && idx == 4'h1 && !rd && sda) next_err = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    {scl_q, sda_q} <= {scl, sda};
    {cnt, idx, sh, rd, err} <= rst ? '0 : {next_cnt, next_idx, next_sh, next_rd, next_err};
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_start; start; endsequence
  sequence s_stop; stop; endsequence
  sequence s_ack_slot; ninth; endsequence
  sequence s_host_nack; ninth && rd && idx != 4'h0 && sda; endsequence

  edge_only_a: assert property ($changed(dev_sda_oe_n) |-> !scl)
    else $error("device data changed while clock high");
  open_drain_a: assert property (!dev_sda_out && !host_sda_out)
    else $error("data driven high");
  start_release_a: assert property (s_start |-> dev_sda_oe_n)
    else $error("device drives data at start");
  stop_quiet_a: assert property (s_stop |-> dev_sda_oe_n [*8])
    else $error("device drives data after stop");
  addr_ack_a: assert property (s_ack_slot ##0 (idx == 4'h0 && sh[7:1] == `DAC_DEV_ADDR) |-> !dev_sda_oe_n)
    else $error("own address not acknowledged");
  cmd_check_a: assert property (s_ack_slot ##0 (idx == 4'h1 && !rd) |-> (sda == !cmd_ok))
    else $error("command byte answer wrong");
  error_quiet_a: assert property (err |-> dev_sda_oe_n)
    else $error("device drives data after command error");
  host_slot_a: assert property (s_ack_slot ##0 (rd && idx != 4'h0) |-> dev_sda_oe_n)
    else $error("device drives host acknowledge slot");
  nack_release_a: assert property (s_host_nack |-> ##14 dev_sda_oe_n [*8])
    else $error("device drives data after host nack");
endmodule

/* verification/test_i2c_read_command_path.sv */
`timescale 1ns/1ps
`include "dac_defs.svh"
module test_i2c_read_command_path
  import dac_pkg::*;
;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic       core_clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, cmd_last = 1'b0, rd_ready = 1'b0;
  logic       output_latch_pin = 1'b0, high_voltage_command_flag = 1'b0, stall = 1'b0;
  logic       cmd_ready, rd_valid, done, nack, cmd_error;
  dac_addr_t  cmd_addr = 5'h00, ptr = `DAC_PTR_RST;
  logic [3:0] cmd_words = 4'h1;
  dac_word_t  rd_data, vol_reg0, vol_reg1, vol_out0, vol_out1, vref_cfg, pd_cfg, gain_cfg;
  dac_word_t  exp_q[$];
  logic       nack_q[$];
  int         err_count = 0, num_checks = 0, cycles = 0;

  dac_i2c_if lnk ();
  dac_host u_dac_host (
    .core_clk, .rst, .cmd_valid, .cmd_ready, .cmd_last, .cmd_addr, .cmd_words,
    .rd_data, .rd_valid, .rd_ready, .done, .nack, .lnk (lnk)
  );
  dac_dev u_dac_dev (
    .core_clk, .rst, .output_latch_pin, .high_voltage_command_flag, .vol_reg0, .vol_reg1,
    .vol_out0, .vol_out1, .vref_cfg, .pd_cfg, .gain_cfg, .cmd_error, .lnk (lnk)
  );
  dac_link_properties u_dac_link_properties (
    .core_clk (core_clk), .rst (rst), .scl (lnk.scl), .host_sda_out (lnk.host_sda_out),
    .host_sda_oe_n (lnk.host_sda_oe_n), .dev_sda_out (lnk.dev_sda_out),
    .dev_sda_oe_n (lnk.dev_sda_oe_n), .sda (lnk.sda)
  );

  always #2.5 core_clk = ~core_clk;

  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic compare(input dac_word_t exp, input dac_word_t got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  task automatic summarize();
    if (err_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 90000) begin
      err_count++;
      summarize();
    end
  end

  // Random consumer; stall holds it off so the buffer fills
  always @(posedge core_clk) rd_ready <= #1 !stall && ($urandom % 4 != 0);

  always @(posedge core_clk) begin
    if (rd_valid === 1'b1 && rd_ready === 1'b1) compare(exp_q.pop_front(), rd_data);
    if (done === 1'b1) compare({15'h0000, nack_q.pop_front()}, {15'h0000, nack});
  end

  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  function automatic dac_word_t model(input dac_addr_t a);
    case (a)
      `DAC_ADR_VOL0: return output_latch_pin ? vol_out0 : vol_reg0;
      `DAC_ADR_VOL1: return output_latch_pin ? vol_out1 : vol_reg1;
      `DAC_ADR_VREF: return vref_cfg;
      `DAC_ADR_PD:   return pd_cfg;
      default:       return gain_cfg;
    endcase
  endfunction

  // Values only change while the bus is idle: the link copy lags the core
  task automatic load_regs();
    {vol_reg0, vol_reg1, vol_out0, vol_out1} = {$urandom, $urandom};
    {vref_cfg, pd_cfg, gain_cfg} = {$urandom, 16'($urandom)};
  endtask

  task automatic run_cmd(input logic last, input dac_addr_t adr, input logic [3:0] n, input logic bad);
    @(posedge core_clk);
    #1;
    high_voltage_command_flag = 1'($urandom);
    cmd_valid = 1'b1;
    cmd_last  = last;
    cmd_addr  = adr;
    cmd_words = n;
    if (!last && !bad) ptr = adr;
    for (int k = 0; k < ((n == 4'h0) ? 1 : n) && !bad; k++) exp_q.push_back(model(ptr));
    nack_q.push_back(bad);
    @(posedge core_clk);
    while (cmd_ready !== 1'b1) @(posedge core_clk);
    #1;
    cmd_valid = 1'b0;
    while (done !== 1'b1) @(posedge core_clk);
    #1;
  endtask

  initial begin
    dac_addr_t good [5];
    dac_addr_t bad [3];
    int        seed;
    good = '{`DAC_ADR_VOL0, `DAC_ADR_VOL1, `DAC_ADR_VREF, `DAC_ADR_PD, `DAC_ADR_GAIN};
    bad  = '{5'h02, 5'h0B, 5'h1F};
    seed = $urandom(11010);
    load_regs();
    // Host runs the bus clock after release so the target can clear its link side
    repeat (16) @(posedge core_clk);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge core_clk);
    foreach (good[i]) run_cmd(1'b0, good[i], 4'(i % 3 + 1), 1'b0);
    output_latch_pin = 1'b1;
    load_regs();
    run_cmd(1'b0, `DAC_ADR_VOL0, 4'h2, 1'b0);
    run_cmd(1'b0, `DAC_ADR_VOL1, 4'h1, 1'b0);
    run_cmd(1'b1, 5'h00, 4'h3, 1'b0);
    output_latch_pin = 1'b0;
    foreach (bad[i]) begin
      run_cmd(1'b0, bad[i], 4'h1, 1'b1);
      repeat (8) @(posedge core_clk);
      #1;
      compare(16'h0001, {15'h0000, cmd_error});
    end
    run_cmd(1'b0, `DAC_ADR_VREF, 4'h1, 1'b0);
    repeat (8) @(posedge core_clk);
    #1;
    compare(16'h0000, {15'h0000, cmd_error});
    stall = 1'b1;
    fork
      run_cmd(1'b0, `DAC_ADR_PD, 4'hF, 1'b0);
      begin
        repeat (3000) @(posedge core_clk);
        #1;
        compare(16'h0001, {14'h0000, lnk.scl, rd_valid});
        stall = 1'b0;
      end
    join
    run_cmd(1'b1, 5'h00, 4'h0, 1'b0);
    repeat (6) begin
      load_regs();
      run_cmd(1'b0, good[$urandom % 5], 4'($urandom % 4), 1'b0);
      run_cmd(1'b1, 5'h00, 4'h1, 1'b0);
    end
    compare(16'h0000, 16'(exp_q.size()));
    summarize();
  end
endmodule
